// File: src/dual_dac_regs.vh
// Constants of the dual converter serial load front end and APB map
//
// Overview of operation
// - Sample serial data on each of the first sixteen falling shift clock edges of a frame.
// - Frame sync falling edge restarts bit counter and input shift logic.
// - One transfer carries exactly one sixteen bit word.
// - Load strobe falling edge copies both pending codes to output latches.
// - Load strobe held low updates both outputs on sixteenth clock edge.
// - Clear low forces both channel latches to all zeros.
// - Format select low means binary or offset binary, high twos complement.
// - Only sixteen bits accepted per frame; further clock edges are ignored.
// - Bit twelve of the word selects channel A when zero, B when one.
// - Word order: three ignored bits, select bit, twelve bits MSB first.
`ifndef DUAL_DAC_REGS_VH
`define DUAL_DAC_REGS_VH

`define WORD_BITS 16
`define CODE_BITS 12
`define CNT_BITS 5
`define SEL_POS 12
`define CODE_MSB 11
`define CNT_ZERO 5'h00
`define CNT_FULL 5'h10
`define CODE_ZERO 12'h000
`define WORD_ZERO 16'h0000
`define SYNC_IDLE 2'h3
// Pin idle levels after reset: clear, strobe, frame and clock high, data low
`define SYNC_RST 5'h1b
`define CNT_STEP 5'h01

`define ADDR_BITS 4
`define OFS_LATCH_A 4'h0
`define OFS_LATCH_B 4'h4
`define OFS_HOLD 4'h8
`define OFS_STATUS 4'hc
`define DATA_ZERO 32'h00000000

`endif

// File: src/dual_dac_serial_load_control.v
// Serial load control of a dual twelve bit converter with APB status view
//
// The address map and the APB interface to the registers are this design's own decisions.
`include "dual_dac_regs.vh"

module dual_dac_serial_load_control (
  input wire mclk,
  input wire sys_rst,
  input wire shift_clk,
  input wire frame_sync_n,
  input wire serial_data_in,
  input wire load_strobe_n,
  input wire clear_n,
  input wire code_format_select,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [11:0] latch_a_q,
  output reg [11:0] latch_b_q,
  output reg format_twos_q
);

  // Two stage synchronisers for the five serial and control pins; stage one is read only by stage two
  reg [4:0] meta_q;
  reg [4:0] sync_q;
  reg sclk_prev_q;
  reg fs_prev_q;
  reg ld_prev_q;
  wire sclk_s = sync_q[0];
  wire fs_n_s = sync_q[1];
  wire sdi_s = sync_q[2];
  wire ld_n_s = sync_q[3];
  wire clr_n_s = sync_q[4];

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= `SYNC_RST;
      sync_q <= `SYNC_RST;
      sclk_prev_q <= 1'b1;
      fs_prev_q <= 1'b1;
      ld_prev_q <= 1'b1;
    end else begin
      meta_q <= {clear_n, load_strobe_n, serial_data_in, frame_sync_n,
                 shift_clk};
      sync_q <= meta_q;
      sclk_prev_q <= sclk_s;
      fs_prev_q <= fs_n_s;
      ld_prev_q <= ld_n_s;
    end
  end

  // Edge detection on the synchronised copies
  wire sclk_fall = sclk_prev_q & ~sclk_s;
  wire fs_fall = fs_prev_q & ~fs_n_s;
  wire ld_fall = ld_prev_q & ~ld_n_s;

  // Shift register, counter and holding registers
  reg [15:0] shift_q;
  reg [4:0] count_q;
  reg [11:0] hold_a_q;
  reg [11:0] hold_b_q;
  reg [15:0] shift_d;
  reg [4:0] count_d;
  reg word_done;

  // Counter gate: stray clock edges after the word are locked out
  wire accept = ~fs_n_s & (count_q != `CNT_FULL);

  always @* begin
    shift_d = shift_q;
    count_d = count_q;
    word_done = 1'b0;
    if (fs_fall) begin
      shift_d = `WORD_ZERO;
      count_d = `CNT_ZERO;
    end else if (sclk_fall && accept) begin
      // First bit in ends up at the top: MSB first order
      shift_d = {shift_q[14:0], sdi_s};
      count_d = count_q + `CNT_STEP;
      word_done = (count_d == `CNT_FULL);
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= `WORD_ZERO;
      count_q <= `CNT_FULL;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
    end
  end

  // Completed word routed to a holding register; the latch takes it only on a load
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_a_q <= `CODE_ZERO;
      hold_b_q <= `CODE_ZERO;
    end else if (word_done) begin
      if (shift_d[`SEL_POS])
        hold_b_q <= shift_d[`CODE_MSB:0];
      else
        hold_a_q <= shift_d[`CODE_MSB:0];
    end
  end

  // Auto update when the strobe is already low at the last bit
  wire auto_load = word_done & ~ld_n_s;

  // Output latches; clear wins over any load while it is held
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_a_q <= `CODE_ZERO;
      latch_b_q <= `CODE_ZERO;
    end else if (!clr_n_s) begin
      latch_a_q <= `CODE_ZERO;
      latch_b_q <= `CODE_ZERO;
    end else if (auto_load) begin
      // Word just finished is taken from shift_d, a cycle ahead of hold
      latch_a_q <= shift_d[`SEL_POS] ? hold_a_q : shift_d[`CODE_MSB:0];
      latch_b_q <= shift_d[`SEL_POS] ? shift_d[`CODE_MSB:0] : hold_b_q;
    end else if (ld_fall) begin
      latch_a_q <= hold_a_q;
      latch_b_q <= hold_b_q;
    end
  end

  // Static format pin, only flagged for the analog stage and the status word
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      format_twos_q <= 1'b0;
    else
      format_twos_q <= code_format_select;
  end

  // Read decode shared by the APB read path
  function [31:0] read_mux;
    input [3:0] ofs;
    input [11:0] la;
    input [11:0] lb;
    input [11:0] ha;
    input [11:0] hb;
    input [4:0] cnt;
    input fmt;
    input fs;
    begin
      case (ofs)
        `OFS_LATCH_A: read_mux = {20'h00000, la};
        `OFS_LATCH_B: read_mux = {20'h00000, lb};
        `OFS_HOLD: read_mux = {8'h00, hb, ha};
        `OFS_STATUS: read_mux = {25'h0000000, fs, fmt, cnt};
        default: read_mux = `DATA_ZERO;
      endcase
    end
  endfunction

  // APB slave: one wait state, read-only map, writes and misses flag error
  wire mapped = (paddr[31:`ADDR_BITS] == 28'h0000000) &
                (paddr[1:0] == 2'h0);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= `DATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= pwrite | ~mapped;
      prdata <= (pwrite | ~mapped) ? `DATA_ZERO :
                read_mux(paddr[3:0], latch_a_q, latch_b_q, hold_a_q,
                         hold_b_q, count_q, format_twos_q, fs_n_s);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// File: dv/host_link_model.sv
// Host side frame driver for the serial load link
module host_link_model (
  input logic mclk,
  output logic sclk = 1'b1,
  output logic fs_n = 1'b1,
  output logic sdi = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bits move while the clock is high, so each fall finds them settled
  task automatic send(input logic [15:0] w, input int n);
    fs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi <= (i < 16) ? w[15 - i] : ~sdi;
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge mclk);
    fs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// File: dv/dac_chk_sva.sv
// Checker of latches, format copy and bus answers
module dac_chk (
  input logic mclk,
  input logic sys_rst,
  input logic load_strobe_n,
  input logic clear_n,
  input logic code_format_select,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  input logic format_twos_q,
  input logic [31:0] paddr,
  input logic [31:0] prdata,
  input logic [11:0] latch_a_q,
  input logic [11:0] latch_b_q
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Clear goes through a synchroniser, hence five cycles
  AST_CLR: assert property (!clear_n[*5] |-> !(latch_a_q|latch_b_q))
    else $error("no clear");
  AST_FMT:
  assert property (1 |=> format_twos_q == $past(code_format_select))
    else $error("bad format");
  AST_HOLD:
  assert property ((load_strobe_n & clear_n)[*5] |=>
    $stable({latch_a_q, latch_b_q})) else $error("latch moved");
  AST_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("long ready");
  AST_WERR: assert property (pready && pwrite |-> pslverr && !prdata)
    else $error("write taken");
  AST_RDA: assert property (pready && !pwrite && paddr == 32'h0 |->
    prdata == $past(latch_a_q)) else $error("read a");
  AST_RDB: assert property (pready && !pwrite && paddr == 32'h4 |->
    prdata == $past(latch_b_q)) else $error("read b");
  cover property (pready && pslverr);
  cover property ($fell(load_strobe_n));
  cover property (!clear_n[*5]);
endmodule
bind dual_dac_serial_load_control dac_chk chk (.*);

// File: dv/tb_top.sv
// Self-checking bench of the dual converter serial load front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic load_strobe_n = 1'b1, clear_n = 1'b1, code_format_select = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, format_twos_q;
  logic shift_clk, frame_sync_n, serial_data_in;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [11:0] latch_a_q, latch_b_q, ca, cb;
  logic [32:0] exq[$];
  int num_errors = 0, cmp_count = 0;
  dual_dac_serial_load_control dut (.*);
  host_link_model hm (.mclk(mclk), .sclk(shift_clk), .fs_n(frame_sync_n),
    .sdi(serial_data_in));
  initial forever #5 mclk = ~mclk;
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One bus access; the answer is noted for the monitor
  task automatic rd(input logic [31:0] a, input logic w, input logic [32:0] e);
    int n;
    n = 0;
    exq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk);
    while (pready !== 1'b1 && n++ < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n > 50) begin
      num_errors++;
      complete_run();
    end
    @(posedge mclk);
  endtask
  // Oldest note against each answer
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      cmp_count++;
      if (exq.size() == 0 || exq.pop_front() !== {pslverr, prdata}) begin
        num_errors++;
        $display("BAD %0t answer %h", $time, prdata);
      end
    end
  end
  initial begin
    void'($urandom(32'h2f01));
    ca = 12'($urandom);
    cb = 12'($urandom);
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(32'h0, 1'b0, 33'h0);
    rd(32'h4, 1'b1, 33'h100000000);
    rd(32'h10, 1'b0, 33'h100000000);
    $display("bus test done");
    hm.send(16'hffff, 5);
    hm.send({4'he, ca}, 18);
    hm.send({4'h1, cb}, 16);
    rd(32'h8, 1'b0, {9'h0, cb, ca});
    rd(32'h0, 1'b0, 33'h0);
    load_strobe_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(32'h0, 1'b0, {21'h0, ca});
    rd(32'h4, 1'b0, {21'h0, cb});
    $display("strobe test done");
    ca = 12'($urandom);
    hm.send({4'h0, ca}, 16);
    rd(32'h0, 1'b0, {21'h0, ca});
    $display("auto test done");
    code_format_select <= 1'b1;
    clear_n <= 1'b0;
    repeat (6) @(posedge mclk);
    clear_n <= 1'b1;
    rd(32'h4, 1'b0, 33'h0);
    rd(32'hc, 1'b0, 33'h70);
    $display("clear test done");
    complete_run();
  end
endmodule
